// File: verilog/ahf_pkg.sv
// Package with the map, field positions and types of the ATA FIFO and UDMA timing block.
package ahf_pkg;
    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [15:0] OFS_UDMA_TIMING_TWO = 16'h3A1C;
    localparam logic [15:0] OFS_UDMA_TIMING_THREE = 16'h3A20;
    localparam logic [15:0] OFS_UDMA_TIMING_FOUR = 16'h3A24;
    localparam logic [15:0] OFS_UDMA_TIMING_FIVE = 16'h3A28;
    localparam logic [15:0] OFS_FIFO_DATA_PORT = 16'h3A3C;
    localparam logic [15:0] OFS_FIFO_STATUS = 16'h3A40;
    localparam logic [15:0] OFS_FIFO_CONTROL = 16'h3A44;
    localparam logic [15:0] OFS_FIFO_ALARM_LEVEL = 16'h3A48;
    localparam logic [15:0] OFS_FIFO_READ_POINTER = 16'h3A4C;
    localparam logic [15:0] OFS_FIFO_WRITE_POINTER = 16'h3A50;
    localparam logic [15:0] OFS_FIFO_COMMAND = 16'h3A54;
    // ****************************************
    // Field positions, bit 0 is the least significant bit
    // ****************************************
    localparam int ERR_BIT = 22;
    localparam int UF_BIT = 21;
    localparam int OF_BIT = 20;
    localparam int FULL_BIT = 19;
    localparam int HI_BIT = 18;
    localparam int LO_BIT = 17;
    localparam int EMPTY_BIT = 16;
    localparam int EOF_BIT = 29;
    localparam int GR_LSB = 24;
    localparam int CMD_FLUSH_BIT = 0;
    localparam int CMD_TX_BIT = 1;
    localparam int ZAH_LSB = 24;
    // ****************************************
    // Reset values and sizes
    // ****************************************
    localparam logic [31:0] REG_RESET = 32'h00000000;
    localparam logic [11:0] PTR_RESET = 12'h000;
    localparam logic [9:0] FIFO_BYTES = 10'h200;
    localparam logic [9:0] WORD_BYTES = 10'h004;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic [7:0] data_setup;
        logic [7:0] data_hold;
        logic [7:0] first_strobe;
        logic [7:0] interlock_max;
        logic [7:0] interlock_min;
        logic [7:0] release_max;
        logic [7:0] envelope;
        logic [7:0] strobe_to_ready;
        logic [7:0] strobe_to_stop;
        logic [7:0] ready_to_final;
        logic [7:0] ready_to_pause;
        logic [7:0] ack_setup_hold_count;
        logic [7:0] drive_delay_min;
    } ahf_timing_t;
    typedef enum logic [3:0] {
        SEL_DATA_SETUP = 4'h0, SEL_DATA_HOLD = 4'h1, SEL_FIRST_STROBE = 4'h2,
        SEL_INTERLOCK_MAX = 4'h3, SEL_INTERLOCK_MIN = 4'h4, SEL_RELEASE_MAX = 4'h5,
        SEL_ENVELOPE = 4'h6, SEL_STROBE_TO_READY = 4'h7, SEL_STROBE_TO_STOP = 4'h8,
        SEL_READY_TO_FINAL = 4'h9, SEL_READY_TO_PAUSE = 4'hA, SEL_ACK_SETUP = 4'hB,
        SEL_DRIVE_DELAY = 4'hC
    } ahf_tsel_t;
endpackage : ahf_pkg

// File: verilog/ahf_fifo_ram.sv
// FIFO storage built from four byte-wide memories.
`timescale 1ns/1ps
module ahf_fifo_ram #(
    parameter int DEPTH = 128,
    parameter int AW = 7
) (
    input wire logic hclk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [31:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [31:0] rd_data
);
    for (genvar lane = 0; lane < 4; lane++) begin : g_lane
        logic [7:0] mem [DEPTH];
        always_ff @(posedge hclk) begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data[lane*8 +: 8];
            end
        end
        assign rd_data[lane*8 +: 8] = mem[rd_addr];
    end
endmodule : ahf_fifo_ram

// File: verilog/ahf_core.sv
// ATA host data FIFO with UDMA timing registers behind an AHB-Lite slave.
// Notes on behaviour
// - Write data setup and hold counts come from timing two, high bytes.
// - First strobe count comes from timing two, third field.
// - Interlock maximum from timing two, minimum from timing three.
// - Bus release maximum in timing three, drive delay minimum in timing five.
// - Envelope count from ack to stop and ready is in timing three.
// - Strobe to ready count in timing three bounds extra words received.
// - Strobe to termination count lives in timing four.
// - No strobe edges after ready-to-final count once ready drops.
// - Recipient waits ready-to-pause count before pausing.
// - Ack setup and hold count lives in timing four bottom field.
// - One FIFO whose direction follows mode; software flushes before switching.
// - Storage is 512 bytes as four 8 by 128 memories.
// - In receive, reading the data port pops the oldest word; in transmit, writing pushes one.
// - A data port access that is not a full word raises an error.
// - Summary error is the OR of other errors; write one clears.
// - Reading past empty sets underflow; flush or write one clears.
// - Writing past full sets overflow; flush or write one clears.
// - Full and empty follow the live state and are not sticky.
// - High attention follows the high mark; low attention holds until the high mark.
// - In transmit, data request asserts at or below the alarm level until the high mark; in receive it follows the high mark.
// - Granularity sets the high mark at four times its value in free bytes.
// - Read pointer is the RAM read address; software writes may corrupt data.
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module ahf_core (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [15:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ata_push,
    input wire logic [31:0] ata_push_data,
    input wire logic ata_pop,
    output logic [31:0] ata_pop_data,
    input wire logic timer_start,
    input wire ahf_pkg::ahf_tsel_t timer_sel,
    output logic timer_done,
    output ahf_pkg::ahf_timing_t udma_timing,
    output logic fifo_dma_request,
    output logic fifo_tx_mode,
    output logic fifo_full,
    output logic fifo_empty
);
    // ****************************************
    // Bus address and data phases
    // ****************************************
    logic ap_valid_q;
    logic ap_write_q;
    logic [15:0] ap_addr_q;
    logic [31:0] hrdata_q;
    wire acc = hsel & htrans[1] & hready;
    wire acc_rd = acc & ~hwrite;
    wire dp_write = ap_valid_q & ap_write_q;
    wire hit_data = haddr == ahf_pkg::OFS_FIFO_DATA_PORT;
    wire size_word = hsize == ahf_pkg::HSIZE_WORD;
    wire wr_t2 = dp_write & (ap_addr_q == ahf_pkg::OFS_UDMA_TIMING_TWO);
    wire wr_t3 = dp_write & (ap_addr_q == ahf_pkg::OFS_UDMA_TIMING_THREE);
    wire wr_t4 = dp_write & (ap_addr_q == ahf_pkg::OFS_UDMA_TIMING_FOUR);
    wire wr_t5 = dp_write & (ap_addr_q == ahf_pkg::OFS_UDMA_TIMING_FIVE);
    wire wr_stat = dp_write & (ap_addr_q == ahf_pkg::OFS_FIFO_STATUS);
    wire wr_ctrl = dp_write & (ap_addr_q == ahf_pkg::OFS_FIFO_CONTROL);
    wire wr_alarm = dp_write & (ap_addr_q == ahf_pkg::OFS_FIFO_ALARM_LEVEL);
    wire wr_rp = dp_write & (ap_addr_q == ahf_pkg::OFS_FIFO_READ_POINTER);
    wire wr_wp = dp_write & (ap_addr_q == ahf_pkg::OFS_FIFO_WRITE_POINTER);
    wire wr_cmd = dp_write & (ap_addr_q == ahf_pkg::OFS_FIFO_COMMAND);
    wire wr_dport = dp_write & (ap_addr_q == ahf_pkg::OFS_FIFO_DATA_PORT);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid_q <= 1'b0;
            ap_write_q <= 1'b0;
            ap_addr_q <= 16'h0000;
        end else begin
            ap_valid_q <= acc & (~hit_data | size_word);
            ap_write_q <= hwrite;
            ap_addr_q <= haddr;
        end
    end

    // ****************************************
    // Software registers
    // ****************************************
    logic [31:0] t2_q, t3_q, t4_q;
    logic [7:0] t5_q;
    logic eof_q;
    logic [2:0] gr_q;
    logic [11:0] alarm_q;
    logic tx_q;
    logic flush_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            t2_q <= ahf_pkg::REG_RESET;
            t3_q <= ahf_pkg::REG_RESET;
            t4_q <= ahf_pkg::REG_RESET;
            t5_q <= 8'h00;
            eof_q <= 1'b0;
            gr_q <= 3'h0;
            alarm_q <= 12'h000;
            tx_q <= 1'b0;
            flush_q <= 1'b0;
        end else begin
            if (wr_t2) t2_q <= hwdata;
            if (wr_t3) t3_q <= hwdata;
            if (wr_t4) t4_q <= hwdata;
            if (wr_t5) t5_q <= hwdata[ahf_pkg::ZAH_LSB +: 8];
            if (wr_ctrl) eof_q <= hwdata[ahf_pkg::EOF_BIT];
            if (wr_ctrl) gr_q <= hwdata[ahf_pkg::GR_LSB +: 3];
            if (wr_alarm) alarm_q <= hwdata[11:0];
            if (wr_cmd) tx_q <= hwdata[ahf_pkg::CMD_TX_BIT];
            flush_q <= wr_cmd & hwdata[ahf_pkg::CMD_FLUSH_BIT];
        end
    end

    // ****************************************
    // Timing fields toward the transfer engine
    // ****************************************
    ahf_pkg::ahf_timing_t tim_d;
    ahf_pkg::ahf_timing_t tim_q;
    // Setup and hold for write data.
    assign tim_d.data_setup = t2_q[31:24];
    assign tim_d.data_hold = t2_q[23:16];
    assign tim_d.first_strobe = t2_q[15:8];
    assign tim_d.interlock_max = t2_q[7:0];
    assign tim_d.interlock_min = t3_q[31:24];
    assign tim_d.release_max = t3_q[23:16];
    assign tim_d.drive_delay_min = t5_q;
    assign tim_d.envelope = t3_q[15:8];
    assign tim_d.strobe_to_ready = t3_q[7:0];
    assign tim_d.strobe_to_stop = t4_q[31:24];
    assign tim_d.ready_to_final = t4_q[23:16];
    assign tim_d.ready_to_pause = t4_q[15:8];
    assign tim_d.ack_setup_hold_count = t4_q[7:0];

    // Picks the count of one timing interval.
    function automatic logic [7:0] pick(input ahf_pkg::ahf_timing_t t, input ahf_pkg::ahf_tsel_t s);
        case (s)
            ahf_pkg::SEL_DATA_SETUP: pick = t.data_setup;
            ahf_pkg::SEL_DATA_HOLD: pick = t.data_hold;
            ahf_pkg::SEL_FIRST_STROBE: pick = t.first_strobe;
            ahf_pkg::SEL_INTERLOCK_MAX: pick = t.interlock_max;
            ahf_pkg::SEL_INTERLOCK_MIN: pick = t.interlock_min;
            ahf_pkg::SEL_RELEASE_MAX: pick = t.release_max;
            ahf_pkg::SEL_ENVELOPE: pick = t.envelope;
            ahf_pkg::SEL_STROBE_TO_READY: pick = t.strobe_to_ready;
            ahf_pkg::SEL_STROBE_TO_STOP: pick = t.strobe_to_stop;
            ahf_pkg::SEL_READY_TO_FINAL: pick = t.ready_to_final;
            ahf_pkg::SEL_READY_TO_PAUSE: pick = t.ready_to_pause;
            ahf_pkg::SEL_ACK_SETUP: pick = t.ack_setup_hold_count;
            default: pick = t.drive_delay_min;
        endcase
    endfunction : pick

    // Interval timer: done pulses count plus two cycles after start.
    logic [7:0] tcnt_q;
    logic tbusy_q;
    logic tdone_q;
    wire [7:0] tload = pick(tim_d, timer_sel);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tim_q <= '0;
            tcnt_q <= 8'h00;
            tbusy_q <= 1'b0;
            tdone_q <= 1'b0;
        end else begin
            tim_q <= tim_d;
            tdone_q <= tbusy_q & ~timer_start & (tcnt_q == 8'h00);
            if (timer_start) begin
                tcnt_q <= tload;
                tbusy_q <= 1'b1;
            end else if (tbusy_q) begin
                tcnt_q <= tcnt_q - 8'h01;
                tbusy_q <= tcnt_q != 8'h00;
            end
        end
    end

    // ****************************************
    // FIFO pointers and occupancy
    // ****************************************
    logic [11:0] wp_q, rp_q;
    logic [31:0] ram_rd;
    wire [9:0] occ = wp_q[9:0] - rp_q[9:0];
    wire [9:0] free_b = ahf_pkg::FIFO_BYTES - occ;
    wire full = occ == ahf_pkg::FIFO_BYTES;
    wire empty = occ == 10'h000;
    wire [9:0] gran_b = {5'h00, gr_q, 2'h0};
    wire at_high = free_b <= gran_b;
    wire occ_le_alarm = {2'h0, occ} <= alarm_q;
    // Receive: link pushes, bus pops. Transmit: bus pushes, link pops.
    wire bus_push = wr_dport & tx_q;
    wire bus_pop = acc_rd & hit_data & size_word & ~tx_q;
    wire push_req = tx_q ? bus_push : ata_push;
    wire pop_req = tx_q ? ata_pop : bus_pop;
    wire [31:0] push_data = tx_q ? hwdata : ata_push_data;
    wire push_ok = push_req & ~full & ~flush_q;
    wire pop_ok = pop_req & ~empty & ~flush_q;
    // Partial access to the data port.
    wire size_bad = acc & hit_data & ~size_word;
    wire uf_evt = pop_req & empty;
    wire of_evt = push_req & full;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_q <= ahf_pkg::PTR_RESET;
            rp_q <= ahf_pkg::PTR_RESET;
        end else if (flush_q) begin
            wp_q <= ahf_pkg::PTR_RESET;
            rp_q <= ahf_pkg::PTR_RESET;
        end else begin
            if (wr_wp) wp_q <= hwdata[11:0];
            else if (push_ok) wp_q <= {2'h0, wp_q[9:0] + ahf_pkg::WORD_BYTES};
            // Software may move the read pointer.
            if (wr_rp) rp_q <= hwdata[11:0];
            else if (pop_ok) rp_q <= {2'h0, rp_q[9:0] + ahf_pkg::WORD_BYTES};
        end
    end

    // Four byte lanes of 128 entries.
    ahf_fifo_ram #(.DEPTH(128), .AW(7)) u_ram (
        .hclk(hclk),
        .wr_en(push_ok),
        .wr_addr(wp_q[8:2]),
        .wr_data(push_data),
        .rd_addr(rp_q[8:2]),
        .rd_data(ram_rd)
    );

    // ****************************************
    // Status flags and watermarks
    // ****************************************
    logic uf_q, of_q, err_q, hi_q, lo_q, full_q, empty_q;
    logic req_q;
    logic [31:0] pop_data_q;
    wire clr_uf = wr_stat & hwdata[ahf_pkg::UF_BIT];
    wire clr_of = wr_stat & hwdata[ahf_pkg::OF_BIT];
    wire clr_err = wr_stat & hwdata[ahf_pkg::ERR_BIT] & ~uf_q & ~of_q;
    // Low mark sets, high mark releases.
    wire lo_d = (occ_le_alarm & ~at_high) | (lo_q & ~at_high);
    // High attention holds while the high mark stands.
    wire hi_d = at_high;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            uf_q <= 1'b0;
            of_q <= 1'b0;
            err_q <= 1'b0;
            hi_q <= 1'b0;
            lo_q <= 1'b0;
            full_q <= 1'b0;
            empty_q <= 1'b1;
            req_q <= 1'b0;
            pop_data_q <= 32'h00000000;
        end else begin
            uf_q <= uf_evt | (uf_q & ~clr_uf & ~flush_q);
            of_q <= of_evt | (of_q & ~clr_of & ~flush_q);
            // Summary error, cleared only once causes are gone.
            err_q <= uf_evt | of_evt | size_bad | (err_q & ~clr_err);
            hi_q <= hi_d;
            lo_q <= lo_d;
            full_q <= full;
            empty_q <= empty;
            req_q <= tx_q ? lo_d : hi_d;
            if (tx_q & pop_ok) pop_data_q <= ram_rd;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    logic [31:0] rd_val;
    wire [31:0] stat_val = {9'h000, err_q | uf_q | of_q, uf_q, of_q, full_q, hi_q, lo_q,
                            empty_q, 16'h0000};
    always_comb begin
        if (haddr == ahf_pkg::OFS_UDMA_TIMING_TWO) rd_val = t2_q;
        else if (haddr == ahf_pkg::OFS_UDMA_TIMING_THREE) rd_val = t3_q;
        else if (haddr == ahf_pkg::OFS_UDMA_TIMING_FOUR) rd_val = t4_q;
        else if (haddr == ahf_pkg::OFS_UDMA_TIMING_FIVE) rd_val = {t5_q, 24'h000000};
        else if (hit_data) rd_val = size_word ? ram_rd : 32'h00000000;
        else if (haddr == ahf_pkg::OFS_FIFO_STATUS) rd_val = stat_val;
        else if (haddr == ahf_pkg::OFS_FIFO_CONTROL) rd_val = {2'h0, eof_q, 2'h0, gr_q, 24'h0};
        else if (haddr == ahf_pkg::OFS_FIFO_ALARM_LEVEL) rd_val = {20'h00000, alarm_q};
        else if (haddr == ahf_pkg::OFS_FIFO_READ_POINTER) rd_val = {20'h00000, rp_q};
        else if (haddr == ahf_pkg::OFS_FIFO_WRITE_POINTER) rd_val = {20'h00000, wp_q};
        else if (haddr == ahf_pkg::OFS_FIFO_COMMAND) rd_val = {30'h00000000, tx_q, 1'b0};
        else rd_val = 32'h00000000;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h00000000;
        end else if (acc_rd) begin
            hrdata_q <= rd_val;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ata_pop_data = pop_data_q;
    assign timer_done = tdone_q;
    assign udma_timing = tim_q;
    assign fifo_dma_request = req_q;
    assign fifo_tx_mode = tx_q;
    assign fifo_full = full_q;
    assign fifo_empty = empty_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_underflow_set: assert property (uf_evt |=> uf_q && stat_val[ahf_pkg::ERR_BIT])
        else $error("underflow not flagged");
    a_overflow_set: assert property (of_evt |=> of_q && fifo_full)
        else $error("overflow not flagged");
    a_err_summary: assert property ((uf_q || of_q) |-> err_q)
        else $error("summary error missing");
    a_size_error: assert property (size_bad |=> err_q ##1 (!$changed(wp_q[9:0])
        || $past(push_ok) || $past(flush_q) || $past(wr_wp)))
        else $error("partial access not flagged");
    a_occ_bound: assert property (occ <= ahf_pkg::FIFO_BYTES && !(fifo_full && fifo_empty))
        else $error("occupancy out of range");
    a_pop_advance: assert property ((pop_ok && !wr_rp) |=> rp_q[9:0] == $past(rp_q[9:0]) + 10'h004)
        else $error("pop did not advance pointer");
    a_full_live: assert property (full |=> fifo_full ##1 (fifo_full == $past(full)))
        else $error("full does not track");
    a_alarm_low: assert property ((occ_le_alarm && !at_high) |=> lo_q)
        else $error("low attention not raised");
    a_high_mark: assert property (!at_high |=> !hi_q && !(lo_q && !$past(lo_d)))
        else $error("high attention stuck");
    a_gran_zero: assert property ((gr_q == 3'h0 && !full) |-> !at_high)
        else $error("granularity zero released early");
    a_dir_gate: assert property ((!tx_q && ata_pop) |-> !(pop_ok && !bus_pop))
        else $error("link pop in receive mode");
    a_timer_zero: assert property ((timer_start && tload == 8'h00) |=> ##1 timer_done)
        else $error("timer done late");
    a_timer_one: assert property ((timer_start && tload == 8'h01) |=> !timer_done ##2 timer_done)
        else $error("timer count wrong");

    c_reach_full: cover property (push_ok ##1 fifo_full);
    c_underflow: cover property (uf_evt ##1 uf_q);
    c_timer: cover property (timer_start ##[1:300] timer_done);
    c_request: cover property (fifo_dma_request ##1 !fifo_dma_request);
endmodule : ahf_core

// File: bench/ahf_link_model.sv
// Model of the link side that pushes and pops FIFO words.
`timescale 1ns/1ps
module ahf_link_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic fifo_tx_mode,
    input wire logic fifo_empty,
    input wire logic pop_en,
    input wire logic push_go,
    input wire logic [31:0] push_word,
    output logic ata_push,
    output logic [31:0] ata_push_data,
    output logic ata_pop,
    output logic pop_valid
);
    logic [1:0] gap_q;
    // Pops are spaced so that the lagging empty flag is current when sampled.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ata_push <= 1'h0;
            ata_push_data <= 32'h0;
            ata_pop <= 1'h0;
            pop_valid <= 1'h0;
            gap_q <= 2'h0;
        end else begin
            ata_push <= push_go;
            ata_push_data <= push_go ? push_word : ~ata_push_data;
            // pop only in transmit, stop at once when not ready
            ata_pop <= pop_en && fifo_tx_mode && !fifo_empty && gap_q == 2'h0 && !ata_pop;
            gap_q <= ata_pop ? 2'h3 : (gap_q != 2'h0 ? gap_q - 2'h1 : 2'h0);
            pop_valid <= ata_pop;
        end
    end
endmodule : ahf_link_model

// File: bench/tb.sv
// Self-checking bench for the ATA FIFO and UDMA timing block.
`timescale 1ns/1ps
module tb;
    logic hclk, hresetn, hsel, hwrite, hready, hresp, rd_seen, timer_start, timer_done;
    logic pop_en, push_go, ata_push, ata_pop, pop_valid;
    logic fifo_dma_request, fifo_tx_mode, fifo_full, fifo_empty;
    logic [15:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, push_word, ata_push_data, ata_pop_data, w;
    logic [31:0] tr [4];
    logic [63:0] nt;
    logic [63:0] note [$];
    logic [31:0] popq [$];
    ahf_pkg::ahf_tsel_t timer_sel;
    ahf_pkg::ahf_timing_t udma_timing;
    int mismatches, n_tests, cyc, cnt;
    ahf_core dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hready), .hrdata, .hreadyout(hready), .hresp, .ata_push, .ata_push_data,
        .ata_pop, .ata_pop_data, .timer_start, .timer_sel, .timer_done, .udma_timing,
        .fifo_dma_request, .fifo_tx_mode, .fifo_full, .fifo_empty);
    ahf_link_model link (.hclk, .hresetn, .fifo_tx_mode, .fifo_empty, .pop_en, .push_go,
        .push_word, .ata_push, .ata_push_data, .ata_pop, .pop_valid);
    initial begin
        hclk = 1'h0;
        forever #4 hclk = ~hclk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict
    task ahb(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [2:0] sz);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= sz;
        do @(posedge hclk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_seen <= !wr;
        do @(posedge hclk); while (hready !== 1'h1);
        rd_seen <= 1'h0;
    endtask : ahb
    task wr(input logic [15:0] a, input logic [31:0] d);
        ahb(1'h1, a, d, ahf_pkg::HSIZE_WORD);
    endtask : wr
    task rd(input logic [15:0] a, input logic [31:0] exp, input logic [31:0] mask);
        note.push_back({exp, mask});
        ahb(1'h0, a, 32'h0, ahf_pkg::HSIZE_WORD);
    endtask : rd
    always @(posedge hclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            give_verdict;
        end
        if (rd_seen === 1'h1) begin
            nt = note.pop_front();
            check(hrdata & nt[31:0], nt[63:32]);
            check({31'h0, hresp}, 32'h0);
        end
        if (pop_valid === 1'h1) check(ata_pop_data, popq.pop_front());
    end
    initial begin
        {hsel, hwrite, rd_seen, timer_start, pop_en, push_go, hresetn} = 7'h0;
        {haddr, htrans, hsize, hwdata, push_word} = 85'h0;
        timer_sel = ahf_pkg::SEL_DATA_SETUP;
        {mismatches, n_tests, cyc} = 96'h0;
        void'($urandom(63));
        repeat (20) @(posedge hclk);
        hresetn <= 1'h1;
        rd(ahf_pkg::OFS_FIFO_STATUS, 32'h00010000, 32'h00790000);
        rd(16'h3A30, 32'h0, 32'hFFFFFFFF);
        for (int i = 0; i < 4; i++) begin
            tr[i] = $urandom;
            wr(ahf_pkg::OFS_UDMA_TIMING_TWO + 16'(4 * i), tr[i]);
        end
        tr[3][23:0] = 24'h0;
        for (int i = 0; i < 4; i++) rd(ahf_pkg::OFS_UDMA_TIMING_TWO + 16'(4 * i), tr[i], 32'hFFFFFFFF);
        repeat (2) @(posedge hclk);
        #1;
        check(udma_timing[103:72], tr[0]);
        check(udma_timing[71:40], tr[1]);
        check(udma_timing[39:8], tr[2]);
        check({24'h0, udma_timing[7:0]}, {24'h0, tr[3][31:24]});
        for (int i = 0; i < 2; i++) begin
            @(posedge hclk);
            timer_sel <= (i == 0) ? ahf_pkg::SEL_DATA_SETUP : ahf_pkg::SEL_DRIVE_DELAY;
            timer_start <= 1'h1;
            @(posedge hclk);
            timer_start <= 1'h0;
            #1;
            cnt = 1;
            while (timer_done !== 1'h1 && cnt < 400) begin
                @(posedge hclk);
                #1;
                cnt++;
            end
            check(32'(cnt), 32'((i == 0) ? tr[0][31:24] : tr[3][31:24]) + 32'h2);
        end
        wr(ahf_pkg::OFS_FIFO_COMMAND, 32'h3);
        wr(ahf_pkg::OFS_FIFO_CONTROL, 32'h01000000);
        wr(ahf_pkg::OFS_FIFO_ALARM_LEVEL, 32'h8);
        for (int i = 1; i <= 129; i++) begin
            w = $urandom;
            if (i <= 128) popq.push_back(w);
            wr(ahf_pkg::OFS_FIFO_DATA_PORT, w);
            repeat (3) @(posedge hclk);
            #1;
            if (i == 126) check({31'h0, fifo_dma_request}, 32'h1);
            if (i == 127) check({31'h0, fifo_dma_request}, 32'h0);
            if (i == 128) check({31'h0, fifo_full}, 32'h1);
        end
        rd(ahf_pkg::OFS_FIFO_STATUS, 32'h00500000, 32'h00500000);
        wr(ahf_pkg::OFS_FIFO_STATUS, 32'h00100000);
        wr(ahf_pkg::OFS_FIFO_STATUS, 32'h00400000);
        rd(ahf_pkg::OFS_FIFO_STATUS, 32'h0, 32'h00700000);
        pop_en <= 1'h1;
        for (cnt = 0; popq.size() != 0 && cnt < 2000; cnt++) @(posedge hclk);
        pop_en <= 1'h0;
        rd(ahf_pkg::OFS_FIFO_STATUS, 32'h00010000, 32'h00790000);
        #1;
        check({30'h0, fifo_tx_mode, fifo_empty}, 32'h3);
        wr(ahf_pkg::OFS_FIFO_COMMAND, 32'h1);
        for (int i = 0; i < 2; i++) begin
            tr[i] = $urandom;
            @(posedge hclk);
            push_go <= 1'h1;
            push_word <= tr[i];
            @(posedge hclk);
            push_go <= 1'h0;
        end
        for (int i = 0; i < 2; i++) rd(ahf_pkg::OFS_FIFO_DATA_PORT, tr[i], 32'hFFFFFFFF);
        rd(ahf_pkg::OFS_FIFO_READ_POINTER, 32'h8, 32'hFFF);
        rd(ahf_pkg::OFS_FIFO_DATA_PORT, 32'h0, 32'h0);
        rd(ahf_pkg::OFS_FIFO_READ_POINTER, 32'h8, 32'hFFF);
        rd(ahf_pkg::OFS_FIFO_STATUS, 32'h00610000, 32'h00790000);
        wr(ahf_pkg::OFS_FIFO_STATUS, 32'h00200000);
        wr(ahf_pkg::OFS_FIFO_STATUS, 32'h00400000);
        ahb(1'h1, ahf_pkg::OFS_FIFO_DATA_PORT, $urandom, 3'h0);
        rd(ahf_pkg::OFS_FIFO_STATUS, 32'h00400000, 32'h00700000);
        give_verdict;
    end
endmodule : tb
